// [ulm_pkg.sv]
// constants and types for the line modes control block
package ulm_pkg;
  localparam logic [7:0] ULM_OFF_CMD = 8'h00;
  localparam logic [7:0] ULM_OFF_MODE = 8'h04;
  localparam logic [7:0] ULM_OFF_IES = 8'h08;
  localparam logic [7:0] ULM_OFF_IEC = 8'h0C;
  localparam logic [7:0] ULM_OFF_IMV = 8'h10;
  localparam logic [7:0] ULM_OFF_STAT = 8'h14;
  localparam logic [7:0] ULM_OFF_RHR = 8'h18;
  localparam logic [7:0] ULM_OFF_THR = 8'h1C;
  localparam logic [7:0] ULM_OFF_BAUD = 8'h20;
  localparam logic [7:0] ULM_OFF_RTO = 8'h24;
  localparam logic [7:0] ULM_OFF_TTG = 8'h28;
  localparam logic [7:0] ULM_OFF_ETU = 8'h40;
  localparam logic [7:0] ULM_OFF_NER = 8'h44;
  localparam logic [7:0] ULM_OFF_IRF = 8'h4C;
  localparam logic [7:0] ULM_OFF_MAN = 8'h50;
  localparam logic [31:0] ULM_RST_ETU = 32'h0000_0174;
  localparam logic [31:0] ULM_RST_MAN = 32'h3001_1004;
  localparam logic [31:0] ULM_RST_ZERO = 32'h0000_0000;
  // command bits
  localparam int ULM_C_RECEIVER_RESET_CMD = 2;
  localparam int ULM_C_TRANSMITTER_RESET_CMD = 3;
  localparam int ULM_C_RXON = 4;
  localparam int ULM_C_RXOFF = 5;
  localparam int ULM_C_TXON = 6;
  localparam int ULM_C_TXOFF = 7;
  localparam int ULM_C_ERRCLR = 8;
  localparam int ULM_C_BRKON = 9;
  localparam int ULM_C_BRKOFF = 10;
  localparam int ULM_C_TOARM = 11;
  localparam int ULM_C_ADDR = 12;
  localparam int ULM_C_ITCLR = 13;
  localparam int ULM_C_DTRON = 16;
  localparam int ULM_C_DTROFF = 17;
  localparam int ULM_C_RTSON = 18;
  localparam int ULM_C_RTSOFF = 19;
  // mode register fields
  localparam int ULM_M_MODE_LSB = 0;
  localparam int ULM_M_PAR_LSB = 9;
  localparam int ULM_M_CH_LSB = 14;
  localparam logic [3:0] ULM_MODE_RS485 = 4'h1;
  localparam logic [3:0] ULM_MODE_MODEM = 4'h3;
  localparam logic [3:0] ULM_MODE_ISO0 = 4'h4;
  localparam logic [3:0] ULM_MODE_ISO1 = 4'h6;
  localparam logic [2:0] ULM_PAR_MULTI = 3'h6;
  // status bits
  localparam int ULM_S_RXRDY = 0;
  localparam int ULM_S_TXRDY = 1;
  localparam int ULM_S_BREAK_RECEIVED_FLAG = 2;
  localparam int ULM_S_OVERRUN_ERROR_FLAG = 5;
  localparam int ULM_S_FRAME = 6;
  localparam int ULM_S_PARITY_ERROR_FLAG = 7;
  localparam int ULM_S_TMO = 8;
  localparam int ULM_S_TXIDLE = 9;
  localparam int ULM_S_ITER = 10;
  localparam int ULM_S_RING_CHANGE_FLAG = 16;
  localparam int ULM_S_MANE = 20;
  localparam int ULM_S_PIN_LSB = 20;
  // character timing in bit periods
  localparam logic [4:0] ULM_CHAR_BITS = 5'd10;
  localparam logic [4:0] ULM_BRK_TAIL_BITS = 5'd12;
  typedef enum logic [1:0] {ULM_CH_NORMAL, ULM_CH_ECHO, ULM_CH_LOCAL, ULM_CH_REMOTE} ulm_ch_type;
endpackage

// [ulm_route.sv]
// channel routing between pins, transmitter and receiver
`timescale 1ns/1ps
module ulm_route
  import ulm_pkg::*;
(
  // mode
  input wire ulm_pkg::ulm_ch_type channel_routing_field,
  // pins
  input wire logic rxd,
  output logic txd,
  // core side
  input wire logic tx_line,
  output logic rx_line,
  output logic core_off
);
  always_comb
  begin
    unique case (channel_routing_field)
      ULM_CH_NORMAL:
      begin
        txd = tx_line;
        rx_line = rxd;
        core_off = 1'b0;
      end
      ULM_CH_ECHO:
      begin
        txd = rxd;
        rx_line = rxd;
        core_off = 1'b0;
      end
      ULM_CH_LOCAL:
      begin
        txd = 1'b1;
        rx_line = tx_line;
        core_off = 1'b0;
      end
      ULM_CH_REMOTE:
      begin
        txd = rxd;
        rx_line = 1'b1;
        core_off = 1'b1;
      end
    endcase
  end
endmodule

// [ulm_modem_in.sv]
// modem input change detection with read-to-clear flags
`timescale 1ns/1ps
module ulm_modem_in
  import ulm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // modem pins ri, dsr, dcd, cts
  input wire logic [3:0] pins,
  // status read strobe
  input wire logic rd_clr,
  // flags and sampled levels
  output logic [3:0] change_q,
  output logic [3:0] level_q
);
  logic [3:0] change_d;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      level_q <= 4'hF;
    else
      level_q <= pins;
  end
  always_comb
  begin
    change_d = change_q;
    if (rd_clr)
      change_d = 4'h0;
    change_d = change_d | (pins ^ level_q);
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      change_q <= 4'h0;
    else
      change_q <= change_d;
  end
  property p_change_set;
    @(posedge mclk) disable iff (!nrst) (pins[3] != level_q[3]) |=> change_q[3];
  endproperty
  a_change_set: assert property (p_change_set) else $error("cts change not flagged");
  property p_read_clear;
    @(posedge mclk) disable iff (!nrst) (rd_clr && (pins == level_q)) |=> (change_q == 4'h0);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear flags");
endmodule

// [ulm_top.sv]
// line modes control: apb registers, command decode, rts/dtr, break and tx pacing
`timescale 1ns/1ps
module ulm_top
  import ulm_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic rxd,
  output logic txd,
  // modem pins
  output logic rts_n,
  output logic dtr_n,
  input wire logic cts,
  input wire logic dsr,
  input wire logic dcd,
  input wire logic ri,
  // receiver events from the framing core
  input wire logic rx_char_done,
  input wire logic rx_par_err,
  input wire logic rx_frm_err,
  input wire logic rx_ovr_err,
  input wire logic rx_brk_seen,
  input wire logic rx_man_err,
  input wire logic rx_tmo_evt,
  input wire logic iter_evt,
  // core control
  output logic rx_line,
  output logic rx_en,
  output logic rx_rst,
  output logic tmo_wait,
  output logic tx_addr_bit
);
  import ulm_pkg::*;

  logic [31:0] mode_q, baud_q, rto_q, ttg_q, etu_q, irf_q, man_q, imask_q, rhr_q;
  logic [7:0] thr_q, shift_q;
  logic thr_full_q, sending_q, tx_en_q, rx_en_q, dtr_q, rts_q, brk_q, brk_stop_q;
  logic addr_pend_q, addr_cur_q, tmo_wait_q, brk_pend_q;
  logic [3:0] bitcnt_q;
  logic [4:0] brkcnt_q, tailcnt_q;
  logic [7:0] guard_q;
  logic [15:0] div_q;
  logic par_q, frm_q, ovr_q, rxb_q, man_err_q, tmo_q, iter_q, rxrdy_q;
  logic [3:0] chg, lvl;
  logic tx_line, core_off, bit_tick, wr, rd, cmd_wr, stat_rd, tx_idle, mode_rs485, mode_modem;
  logic [31:0] cmd, stat;
  ulm_ch_type channel_routing_field;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign cmd_wr = wr && hit(paddr, ULM_OFF_CMD);
  assign cmd = cmd_wr ? pwdata : 32'h0;
  assign stat_rd = rd && hit(paddr, ULM_OFF_STAT);
  assign mode_rs485 = mode_q[ULM_M_MODE_LSB +: 4] == ULM_MODE_RS485;
  assign mode_modem = mode_q[ULM_M_MODE_LSB +: 4] == ULM_MODE_MODEM;
  assign channel_routing_field = ulm_ch_type'(mode_q[ULM_M_CH_LSB +: 2]);
  assign tx_idle = !thr_full_q && !sending_q && (guard_q == 8'h00) && !brk_q
    && (tailcnt_q == 5'd0);

  ulm_route u_route (
    .channel_routing_field(channel_routing_field),
    .rxd(rxd),
    .txd(txd),
    .tx_line(tx_line),
    .rx_line(rx_line),
    .core_off(core_off)
  );

  ulm_modem_in u_modem (
    .mclk(mclk),
    .nrst(nrst),
    .pins({cts, dcd, dsr, ri}),
    .rd_clr(stat_rd),
    .change_q(chg),
    .level_q(lvl)
  );

  // bit period divider
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      div_q <= 16'h0000;
    else if (bit_tick)
      div_q <= 16'h0000;
    else
      div_q <= div_q + 16'h0001;
  end
  assign bit_tick = (div_q >= baud_q[15:0]);

  // configuration registers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mode_q <= ULM_RST_ZERO;
      baud_q <= ULM_RST_ZERO;
      rto_q <= ULM_RST_ZERO;
      ttg_q <= ULM_RST_ZERO;
      etu_q <= ULM_RST_ETU;
      irf_q <= ULM_RST_ZERO;
      man_q <= ULM_RST_MAN;
      imask_q <= ULM_RST_ZERO;
    end
    else if (wr)
    begin
      if (hit(paddr, ULM_OFF_MODE))
        mode_q <= pwdata;
      if (hit(paddr, ULM_OFF_BAUD))
        baud_q <= pwdata;
      if (hit(paddr, ULM_OFF_RTO))
        rto_q <= pwdata;
      if (hit(paddr, ULM_OFF_TTG))
        ttg_q <= pwdata;
      if (hit(paddr, ULM_OFF_ETU))
        etu_q <= pwdata;
      if (hit(paddr, ULM_OFF_IRF))
        irf_q <= pwdata;
      if (hit(paddr, ULM_OFF_MAN))
        man_q <= pwdata;
      if (hit(paddr, ULM_OFF_IES))
        imask_q <= imask_q | pwdata;
      if (hit(paddr, ULM_OFF_IEC))
        imask_q <= imask_q & ~pwdata;
    end
  end

  // enables and pin commands
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_en_q <= 1'b0;
      tx_en_q <= 1'b0;
      dtr_q <= 1'b1;
      rts_q <= 1'b1;
    end
    else
    begin
      if (cmd[ULM_C_RXOFF] || cmd[ULM_C_RECEIVER_RESET_CMD])
        rx_en_q <= 1'b0;
      else if (cmd[ULM_C_RXON])
        rx_en_q <= 1'b1;
      if (cmd[ULM_C_TXOFF] || cmd[ULM_C_TRANSMITTER_RESET_CMD])
        tx_en_q <= 1'b0;
      else if (cmd[ULM_C_TXON])
        tx_en_q <= 1'b1;
      else if (mode_modem && cts && !sending_q)
        tx_en_q <= 1'b0;
      if (cmd[ULM_C_DTROFF])
        dtr_q <= 1'b1;
      else if (cmd[ULM_C_DTRON])
        dtr_q <= 1'b0;
      if (cmd[ULM_C_RTSOFF])
        rts_q <= 1'b1;
      else if (cmd[ULM_C_RTSON])
        rts_q <= 1'b0;
    end
  end

  // transmit holding, shifter and timeguard
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      thr_q <= 8'h00;
      thr_full_q <= 1'b0;
      shift_q <= 8'h00;
      sending_q <= 1'b0;
      bitcnt_q <= 4'h0;
      guard_q <= 8'h00;
      addr_pend_q <= 1'b0;
      addr_cur_q <= 1'b0;
    end
    else if (cmd[ULM_C_TRANSMITTER_RESET_CMD])
    begin
      thr_full_q <= 1'b0;
      sending_q <= 1'b0;
      bitcnt_q <= 4'h0;
      guard_q <= 8'h00;
      addr_pend_q <= 1'b0;
    end
    else
    begin
      if (cmd[ULM_C_ADDR] && mode_q[ULM_M_PAR_LSB +: 3] == ULM_PAR_MULTI)
        addr_pend_q <= 1'b1;
      if (wr && hit(paddr, ULM_OFF_THR) && !thr_full_q)
      begin
        thr_q <= pwdata[7:0];
        thr_full_q <= 1'b1;
      end
      if (bit_tick)
      begin
        if (sending_q)
        begin
          if (bitcnt_q != 4'h0)
            shift_q <= {1'b1, shift_q[7:1]};
          if (bitcnt_q == 4'(ULM_CHAR_BITS - 5'd1))
          begin
            sending_q <= 1'b0;
            guard_q <= ttg_q[7:0];
          end
          bitcnt_q <= bitcnt_q + 4'h1;
        end
        else if (guard_q != 8'h00)
          guard_q <= guard_q - 8'h01;
        else if (thr_full_q && tx_en_q && !core_off && !brk_q)
        begin
          shift_q <= thr_q;
          sending_q <= 1'b1;
          bitcnt_q <= 4'h0;
          thr_full_q <= 1'b0;
          addr_cur_q <= addr_pend_q;
          addr_pend_q <= 1'b0;
        end
      end
    end
  end
  assign tx_addr_bit = addr_cur_q;

  // break generation, a request waits until holding and shifter drain
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      brk_q <= 1'b0;
      brk_pend_q <= 1'b0;
      brk_stop_q <= 1'b0;
      brkcnt_q <= 5'd0;
      tailcnt_q <= 5'd0;
    end
    else
    begin
      if ((cmd[ULM_C_BRKON] || brk_pend_q) && !brk_q && !thr_full_q && !sending_q
        && tailcnt_q == 5'd0)
      begin
        brk_q <= 1'b1;
        brk_pend_q <= 1'b0;
        brkcnt_q <= 5'd0;
        brk_stop_q <= 1'b0;
      end
      else if (brk_q)
      begin
        if (cmd[ULM_C_BRKOFF])
          brk_stop_q <= 1'b1;
        if (bit_tick && brkcnt_q < ULM_CHAR_BITS)
          brkcnt_q <= brkcnt_q + 5'd1;
        if ((brk_stop_q || cmd[ULM_C_BRKOFF]) && brkcnt_q >= ULM_CHAR_BITS)
        begin
          brk_q <= 1'b0;
          tailcnt_q <= ULM_BRK_TAIL_BITS;
        end
      end
      else
      begin
        if (cmd[ULM_C_TRANSMITTER_RESET_CMD])
          brk_pend_q <= 1'b0;
        else if (cmd[ULM_C_BRKON])
          brk_pend_q <= 1'b1;
        if (bit_tick && tailcnt_q != 5'd0)
          tailcnt_q <= tailcnt_q - 5'd1;
      end
    end
  end

  always_comb
  begin
    if (brk_q)
      tx_line = 1'b0;
    else if (sending_q)
      tx_line = (bitcnt_q == 4'h0) ? 1'b0 : (bitcnt_q == 4'h9 ? 1'b1 : shift_q[0]);
    else
      tx_line = 1'b1;
  end

  // rts selection per line mode
  always_comb
  begin
    if (mode_rs485)
      rts_n = !tx_idle;
    else if (mode_modem)
      rts_n = tx_idle || !tx_en_q;
    else
      rts_n = rts_q;
  end
  assign dtr_n = dtr_q;
  assign rx_en = rx_en_q && !core_off;
  assign rx_rst = cmd[ULM_C_RECEIVER_RESET_CMD];
  assign tmo_wait = tmo_wait_q;

  // receive status flags, hardware set wins over clear, except that a receiver reset command wins over rx_char_done for rxrdy_q
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      par_q <= 1'b0;
      frm_q <= 1'b0;
      ovr_q <= 1'b0;
      rxb_q <= 1'b0;
      man_err_q <= 1'b0;
      tmo_q <= 1'b0;
      iter_q <= 1'b0;
      tmo_wait_q <= 1'b0;
      rxrdy_q <= 1'b0;
      rhr_q <= ULM_RST_ZERO;
    end
    else
    begin
      par_q <= (par_q && !cmd[ULM_C_ERRCLR]) || rx_par_err;
      frm_q <= (frm_q && !cmd[ULM_C_ERRCLR]) || rx_frm_err;
      ovr_q <= (ovr_q && !cmd[ULM_C_ERRCLR]) || rx_ovr_err;
      rxb_q <= (rxb_q && !cmd[ULM_C_ERRCLR]) || rx_brk_seen;
      man_err_q <= (man_err_q && !cmd[ULM_C_ERRCLR]) || rx_man_err;
      tmo_q <= (tmo_q && !cmd[ULM_C_TOARM]) || rx_tmo_evt;
      if (cmd[ULM_C_TOARM])
        tmo_wait_q <= 1'b1;
      else if (rx_char_done)
        tmo_wait_q <= 1'b0;
      iter_q <= (iter_q && !(cmd[ULM_C_ITCLR] && (mode_q[ULM_M_MODE_LSB +: 4] == ULM_MODE_ISO0
        || mode_q[ULM_M_MODE_LSB +: 4] == ULM_MODE_ISO1))) || iter_evt;
      if (cmd[ULM_C_RECEIVER_RESET_CMD])
        rxrdy_q <= 1'b0;
      else if (rx_char_done)
        rxrdy_q <= 1'b1;
      else if (rd && hit(paddr, ULM_OFF_RHR))
        rxrdy_q <= 1'b0;
    end
  end

  always_comb
  begin
    stat = 32'h0;
    stat[ULM_S_RXRDY] = rxrdy_q;
    stat[ULM_S_TXRDY] = !thr_full_q;
    stat[ULM_S_BREAK_RECEIVED_FLAG] = rxb_q;
    stat[ULM_S_OVERRUN_ERROR_FLAG] = ovr_q;
    stat[ULM_S_FRAME] = frm_q;
    stat[ULM_S_PARITY_ERROR_FLAG] = par_q;
    stat[ULM_S_TMO] = tmo_q;
    stat[ULM_S_TXIDLE] = tx_idle;
    stat[ULM_S_ITER] = iter_q;
    stat[ULM_S_RING_CHANGE_FLAG +: 4] = chg;
    stat[ULM_S_MANE] = man_err_q;
    stat[ULM_S_PIN_LSB + 1 +: 4] = lvl;
  end

  always_comb
  begin
    prdata = 32'h0;
    if (rd)
    begin
      unique case (paddr)
        ULM_OFF_MODE: prdata = mode_q;
        ULM_OFF_IMV: prdata = imask_q;
        ULM_OFF_STAT: prdata = stat;
        ULM_OFF_RHR: prdata = rhr_q;
        ULM_OFF_BAUD: prdata = baud_q;
        ULM_OFF_RTO: prdata = rto_q;
        ULM_OFF_TTG: prdata = ttg_q;
        ULM_OFF_ETU: prdata = etu_q;
        ULM_OFF_IRF: prdata = irf_q;
        ULM_OFF_MAN: prdata = man_q;
        default: prdata = 32'h0;
      endcase
    end
  end

  property p_rs485_rts;
    @(posedge mclk) disable iff (!nrst) mode_rs485 |-> (rts_n == !tx_idle);
  endproperty
  a_rs485_rts: assert property (p_rs485_rts) else $error("rs485 rts wrong");
  property p_dtr_off;
    @(posedge mclk) disable iff (!nrst) cmd[ULM_C_DTROFF] |=> dtr_n;
  endproperty
  a_dtr_off: assert property (p_dtr_off) else $error("dtr not released");
  property p_dtr_on;
    @(posedge mclk) disable iff (!nrst) (cmd[ULM_C_DTRON] && !cmd[ULM_C_DTROFF]) |=> !dtr_n;
  endproperty
  a_dtr_on: assert property (p_dtr_on) else $error("dtr not asserted");
  property p_tx_off_wins;
    @(posedge mclk) disable iff (!nrst) cmd[ULM_C_TXOFF] |=> !tx_en_q;
  endproperty
  a_tx_off_wins: assert property (p_tx_off_wins) else $error("tx disable lost");
  property p_err_clear;
    @(posedge mclk) disable iff (!nrst)
      (cmd[ULM_C_ERRCLR] && !rx_par_err && !rx_ovr_err) |=> (!par_q && !ovr_q);
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flags kept");
  property p_local_txd;
    @(posedge mclk) disable iff (!nrst) (channel_routing_field == ULM_CH_LOCAL) |-> txd;
  endproperty
  a_local_txd: assert property (p_local_txd) else $error("local loopback txd low");
  property p_echo;
    @(posedge mclk) disable iff (!nrst) (channel_routing_field inside {ULM_CH_ECHO, ULM_CH_REMOTE}) |-> txd == rxd;
  endproperty
  a_echo: assert property (p_echo) else $error("echo path broken");
  sequence s_brk_go;
    cmd[ULM_C_BRKON] && !brk_q && !thr_full_q && !sending_q && tailcnt_q == 5'd0;
  endsequence
  property p_brk_start;
    @(posedge mclk) disable iff (!nrst) s_brk_go |=> brk_q ##0 !txd || channel_routing_field != ULM_CH_NORMAL;
  endproperty
  a_brk_start: assert property (p_brk_start) else $error("break not started");
  property p_brk_tail;
    @(posedge mclk) disable iff (!nrst) $fell(brk_q) |-> tailcnt_q == ULM_BRK_TAIL_BITS;
  endproperty
  a_brk_tail: assert property (p_brk_tail) else $error("break tail count wrong");
endmodule

// [ulm_modem.sv]
// modem and line transceiver model at the serial pins
`timescale 1ns/1ps
module ulm_modem
(
  // clock
  input wire logic mclk,
  // modem outputs, high is inactive or idle
  output logic rxd,
  output logic cts,
  output logic dsr,
  output logic dcd,
  output logic ri
);
  logic [4:0] lv_q = 5'h1F;
  assign {ri, dsr, dcd, cts, rxd} = lv_q;
  // change the pin levels just after an edge
  task automatic set(input logic [4:0] v);
    @(posedge mclk);
    lv_q <= v;
  endtask
endmodule

// [ulm_top_tb.sv]
// self-checking bench for the line modes control block
`timescale 1ns/1ps
module ulm_top_tb;
  import ulm_pkg::*;
  logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, d, ev = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, rxd, txd, rts_n, dtr_n, cts, dsr, dcd, ri;
  logic rx_line, rx_en, rx_rst, tmo_wait, tx_addr_bit;
  logic [9:0] f, r;
  int n_fail = 0, n_checks = 0, k;
  integer seed = 32'h8F7755E3;
  logic [7:0] ra[7] = '{ULM_OFF_IMV, ULM_OFF_RHR, ULM_OFF_BAUD, ULM_OFF_RTO,
    ULM_OFF_TTG, ULM_OFF_ETU, ULM_OFF_MAN};
  logic [31:0] rv[7] = '{0, 0, 0, 0, 0, ULM_RST_ETU, ULM_RST_MAN};
  logic [31:0] k_cmd[4] = '{32'h10, 32'h30, 32'h10, 32'h04};
  logic k_exp[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  ulm_top ulm_top_inst (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .rts_n(rts_n),
    .dtr_n(dtr_n), .cts(cts), .dsr(dsr), .dcd(dcd), .ri(ri),
    .rx_char_done(ev[0]), .rx_par_err(ev[1]), .rx_frm_err(ev[2]),
    .rx_ovr_err(ev[3]), .rx_brk_seen(ev[4]), .rx_man_err(ev[5]),
    .rx_tmo_evt(ev[6]), .iter_evt(ev[7]), .rx_line(rx_line), .rx_en(rx_en),
    .rx_rst(rx_rst), .tmo_wait(tmo_wait), .tx_addr_bit(tx_addr_bit));
  ulm_modem ulm_modem_inst (.mclk(mclk), .rxd(rxd), .cts(cts), .dsr(dsr),
    .dcd(dcd), .ri(ri));
  initial
  begin
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (w)
      @(posedge mclk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic pulse(input logic [7:0] v);
    @(posedge mclk);
    ev <= v;
    @(posedge mclk);
    ev <= 8'h00;
  endtask
  // wait a bounded time for txd to reach a level
  task automatic wait_txd(input logic lvl);
    k = 0;
    while (txd !== lvl && k < 60)
    begin
      @(posedge mclk);
      k++;
    end
    chk(txd, lvl);
  endtask
  // sample one character mid-bit, four cycles a bit
  task automatic frame(output logic [9:0] fo, output logic [9:0] ro);
    wait_txd(1'b0);
    cyc(2);
    for (int i = 0; i < 10; i++)
    begin
      fo[i] = txd;
      ro[i] = rts_n;
      cyc(4);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    cyc(20000);
    n_fail++;
    final_report;
  end
  initial
  begin
    cyc(4);
    chk({dtr_n, rts_n, txd}, 3'h7);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      apb(0, ra[i], 0);
      chk(rd, rv[i]);
    end
    apb(0, 8'h2C, 0);
    chk(rd, 0);
    chk({pslverr, pready}, 1);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      apb(1, ULM_OFF_RTO + 8'(4 * (i % 2)), {24'h0, d});
      apb(0, ULM_OFF_RTO + 8'(4 * (i % 2)), 0);
      chk(rd, {24'h0, d});
    end
    for (int i = 16; i < 20; i++)
    begin
      apb(1, ULM_OFF_CMD, 1 << i);
      chk(i < 18 ? dtr_n : rts_n, i % 2);
    end
    foreach (k_cmd[i])
    begin
      fork
        apb(1, ULM_OFF_CMD, k_cmd[i]);
        begin
          cyc(3);
          chk(rx_rst, k_cmd[i][ULM_C_RECEIVER_RESET_CMD]);
        end
      join
      chk(rx_en, k_exp[i]);
    end
    for (int m = 0; m < 4; m++)
      for (int b = 0; b < 2; b++)
      begin
        apb(1, ULM_OFF_MODE, m << ULM_M_CH_LSB);
        ulm_modem_inst.set({4'hF, 1'(b ^ $random(seed) % 1)});
        cyc(2);
        chk(txd, (m % 2) ? b : 1);
        if (m < 3)
          chk(rx_line, (m == 2) ? 1 : b);
      end
    apb(1, ULM_OFF_MODE, ULM_MODE_MODEM);
    apb(0, ULM_OFF_STAT, 0);
    for (int j = 0; j < 4; j++)
    begin
      ulm_modem_inst.set(5'h1F ^ 5'(1 << (4 - j)));
      cyc(3);
      apb(0, ULM_OFF_STAT, 0);
      chk(rd[24:16], {4'hF ^ 4'(1 << j), 1'b0, 4'(1 << j)});
      apb(0, ULM_OFF_STAT, 0);
      chk(rd[19:16], 0);
      ulm_modem_inst.set(5'h1F);
      cyc(3);
      apb(0, ULM_OFF_STAT, 0);
    end
    pulse(8'hFE);
    apb(0, ULM_OFF_STAT, 0);
    chk(rd & 32'h001005E4, 32'h001005E4);
    apb(1, ULM_OFF_CMD, 32'h100);
    apb(0, ULM_OFF_STAT, 0);
    chk(rd & 32'h001005E4, 32'h500);
    apb(1, ULM_OFF_CMD, 32'h2800);
    apb(0, ULM_OFF_STAT, 0);
    chk({tmo_wait, rd[10], rd[8]}, 3'h6);
    pulse(8'h01);
    cyc(1);
    chk(tmo_wait, 0);
    apb(1, ULM_OFF_MODE, ULM_MODE_ISO0);
    apb(1, ULM_OFF_CMD, 32'h2000);
    apb(0, ULM_OFF_STAT, 0);
    chk(rd[10], 0);
    apb(1, ULM_OFF_BAUD, 32'h3);
    apb(1, ULM_OFF_TTG, 32'h2);
    apb(1, ULM_OFF_MODE, 32'hC01);
    apb(1, ULM_OFF_CMD, 32'h1040);
    d = 8'($random(seed));
    apb(1, ULM_OFF_THR, {24'h0, d});
    frame(f, r);
    chk(tx_addr_bit, 1);
    chk(f, {1'b1, d, 1'b0});
    chk(r, 10'h3FF);
    cyc(4);
    chk(rts_n, 1);
    k = 0;
    while (rts_n !== 1'b0 && k < 12)
    begin
      cyc(1);
      k++;
    end
    apb(0, ULM_OFF_STAT, 0);
    chk({rts_n, rd[ULM_S_TXIDLE]}, 2'h1);
    ulm_modem_inst.set(5'h1D);
    apb(1, ULM_OFF_MODE, ULM_MODE_MODEM);
    d = 8'($random(seed));
    apb(1, ULM_OFF_THR, {24'h0, d});
    fork
      frame(f, r);
      begin
        cyc(16);
        ulm_modem_inst.set(5'h1F);
      end
    join
    chk(f, {1'b1, d, 1'b0});
    chk(r[8:0], 0);
    chk(tx_addr_bit, 0);
    apb(1, ULM_OFF_THR, 32'h5A);
    k = 0;
    repeat (60)
    begin
      cyc(1);
      k += !txd;
    end
    chk(k, 0);
    ulm_modem_inst.set(5'h1D);
    apb(1, ULM_OFF_MODE, 0);
    apb(1, ULM_OFF_CMD, 32'h08);
    d = 8'($random(seed));
    apb(1, ULM_OFF_THR, {24'h0, d});
    apb(1, ULM_OFF_CMD, 32'h240);
    frame(f, r);
    chk(f, {1'b1, d, 1'b0});
    wait_txd(1'b0);
    fork
      apb(1, ULM_OFF_CMD, 32'h600);
      begin
        k = 0;
        while (txd === 1'b0 && k < 200)
        begin
          cyc(1);
          k++;
        end
      end
    join
    chk(k >= 36, 1);
    apb(0, ULM_OFF_STAT, 0);
    chk({txd, rd[ULM_S_TXIDLE]}, 2'h2);
    final_report;
  end
endmodule
